// [nsr_pkg.sv]
// Purpose: Constants for the node switch routing and debug registers
// Assumes: Register numbers are word indices on the configuration port
// Notes:   Shared by the register bank, its checker and the test bench
package nsr_pkg;
   localparam logic [7:0]  REG_REF_DIV    = 8'h08;
   localparam logic [7:0]  REG_SCAN_ID    = 8'h09;
   localparam logic [7:0]  REG_USER_CODE  = 8'h0a;
   localparam logic [7:0]  REG_NODE_ID    = 8'h05;
   localparam logic [7:0]  REG_DIR_LOW    = 8'h0c;
   localparam logic [7:0]  REG_DIR_HIGH   = 8'h0d;
   localparam logic [7:0]  REG_DBG_TILE0  = 8'h10;
   localparam logic [7:0]  REG_DBG_TILE1  = 8'h11;
   localparam logic [7:0]  REG_DBG_ORIGIN = 8'h1f;
   localparam logic [7:0]  REG_LINK_BASE  = 8'h20;
   localparam int          NUM_LINKS      = 8;
   localparam logic [15:0] REF_DIV_RESET  = 16'h0003;
   // Identification copies: arbitrary neutral values
   localparam logic [31:0] SCAN_ID_VALUE  = 32'h1234_5671;
   localparam logic [31:0] USER_CODE_VAL  = 32'h0000_0000;
   localparam int DBG_REQ_BIT    = 1;
   localparam int DBG_DRIVE_BIT  = 0;
   localparam int ORIG_PIN_BIT   = 4;
   localparam int ORIG_ONE_BIT   = 1;
   localparam int ORIG_ZERO_BIT  = 0;
   localparam int LS_KIND_LO     = 24;
   localparam int LS_DEST_LO     = 16;
   localparam int LS_DIR_LO      = 8;
   localparam int LS_NET_LO      = 4;
   localparam int LS_JUNK_BIT    = 2;
   localparam int LS_DST_USE_BIT = 1;
   localparam int LS_SRC_USE_BIT = 0;
   typedef enum logic [1:0] {
      NSR_SWITCH_LINK    = 2'h0,
      NSR_PROCESSOR_LINK = 2'h1,
      NSR_SWITCH_CONTROL = 2'h2,
      NSR_UNDEFINED      = 2'h3
   } nsr_kind_e;
endpackage

// [nsr_route_if.sv]
// Purpose: Carries a route lookup between the register bank and the lookup
// Assumes: One lookup per cycle
// Notes:   Tables are flat 64 bits, dimension 0 lowest
`timescale 1ns/1ns
interface nsr_route_if;
   logic [15:0] node_id;
   logic [63:0] table_bits;
   logic [15:0] dest_id;
   logic        req;
   logic        local_hit;
   logic [3:0]  direction;
   logic        valid;
   modport bank (output node_id, output table_bits, input local_hit, input direction,
                 input valid, output dest_id, output req);
   modport look (input node_id, input table_bits, input dest_id, input req,
                 output local_hit, output direction, output valid);
endinterface

// [nsr_route_lookup.sv]
// Purpose: Picks the outgoing direction from the top mismatching id bit
// Assumes: Tables stable during a lookup
// Notes:   Result registered, one cycle after the request
`timescale 1ns/1ns
module nsr_route_lookup (
   // Clocking
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   // Lookup
   nsr_route_if.look rt
);
   logic [15:0] diff;
   logic [3:0]  dim;
   always_comb begin
      diff = rt.dest_id ^ rt.node_id;
      dim  = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (diff[i]) begin
            dim = 4'(i);
         end
      end
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rt.valid     <= 1'b0;
         rt.local_hit <= 1'b0;
         rt.direction <= 4'h0;
      end else if (ce_in) begin
         rt.valid     <= rt.req;
         rt.local_hit <= (diff == 16'h0000);
         // A local packet bypasses both tables
         rt.direction <= (diff == 16'h0000) ? 4'h0 : rt.table_bits[{dim, 2'b00} +: 4];
      end
   end
endmodule

// [nsr_regs.sv]
// Purpose: Node switch configuration, routing tables, debug and link status
// Assumes: Single clock; config port reads return data one cycle later
// Notes:   Unmapped numbers read zero and ignore writes
`timescale 1ns/1ns
module nsr_regs #(
   parameter int LINKS = nsr_pkg::NUM_LINKS
) (
   // Clocking
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              ce_in,
   // Configuration port
   input  wire logic              cfg_wr_in,
   input  wire logic              cfg_rd_in,
   input  wire logic [7:0]        cfg_addr_in,
   input  wire logic [31:0]       cfg_wdata_in,
   output logic      [31:0]       cfg_rdata_out,
   output logic                   cfg_rvalid_out,
   // Route lookup
   input  wire logic              route_req_in,
   input  wire logic [15:0]       route_dest_in,
   output logic                   route_valid_out,
   output logic                   route_local_out,
   output logic      [3:0]        route_dir_out,
   output logic      [15:0]       ref_divider_out,
   // Debug
   input  wire logic [1:0]        halted_flag_in,
   input  wire logic              ext_debug_pin_in,
   output logic                   shared_halt_signal_out,
   output logic      [1:0]        core_debug_req_out,
   // Link state from switch
   input  wire logic [2*LINKS-1:0] link_kind_in,
   input  wire logic [8*LINKS-1:0] link_dest_in,
   input  wire logic [LINKS-1:0]   link_junk_in,
   input  wire logic [LINKS-1:0]   link_dst_use_in,
   input  wire logic [LINKS-1:0]   link_src_use_in,
   output logic      [4*LINKS-1:0] link_dir_out,
   output logic      [2*LINKS-1:0] link_net_out
);
   logic [15:0] ref_div_reg;
   logic [15:0] node_id_reg;
   logic [31:0] dir_low_reg;
   logic [31:0] dir_high_reg;
   logic [1:0]  dbg_cfg_reg [2];
   logic [4:0]  origin_reg;
   logic [3:0]  link_dir_reg [LINKS];
   logic [1:0]  link_net_reg [LINKS];
   logic        shared_prev_reg;
   logic        shared_next;
   logic [31:0] rdata_next;
   logic        link_hit;
   logic [7:0]  link_idx;

   nsr_route_if rt ();
   assign rt.node_id    = node_id_reg;
   assign rt.table_bits = {dir_high_reg, dir_low_reg};
   assign rt.dest_id    = route_dest_in;
   assign rt.req        = route_req_in;

   nsr_route_lookup nsr_route_lookup_i (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .rt     (rt.look)
   );

   assign link_idx = cfg_addr_in - nsr_pkg::REG_LINK_BASE;
   assign link_hit = (cfg_addr_in >= nsr_pkg::REG_LINK_BASE)
                   && (link_idx < 8'(LINKS));

   // Plain registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_div_reg  <= nsr_pkg::REF_DIV_RESET;
         node_id_reg  <= 16'h0000;
         dir_low_reg  <= 32'h0000_0000;
         dir_high_reg <= 32'h0000_0000;
         dbg_cfg_reg[0] <= 2'h0;
         dbg_cfg_reg[1] <= 2'h0;
      end else if (ce_in && cfg_wr_in) begin
         if (cfg_addr_in == nsr_pkg::REG_REF_DIV) begin
            ref_div_reg <= cfg_wdata_in[15:0];
         end else if (cfg_addr_in == nsr_pkg::REG_NODE_ID) begin
            node_id_reg <= cfg_wdata_in[15:0];
         end else if (cfg_addr_in == nsr_pkg::REG_DIR_LOW) begin
            dir_low_reg <= cfg_wdata_in;
         end else if (cfg_addr_in == nsr_pkg::REG_DIR_HIGH) begin
            dir_high_reg <= cfg_wdata_in;
         end else if (cfg_addr_in == nsr_pkg::REG_DBG_TILE0) begin
            dbg_cfg_reg[0] <= cfg_wdata_in[1:0];
         end else if (cfg_addr_in == nsr_pkg::REG_DBG_TILE1) begin
            dbg_cfg_reg[1] <= cfg_wdata_in[1:0];
         end
      end
   end

   // Per-link direction and network
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < LINKS; i++) begin
            link_dir_reg[i] <= 4'h0;
            link_net_reg[i] <= 2'h0;
         end
      end else if (ce_in && cfg_wr_in && link_hit) begin
         link_dir_reg[link_idx[2:0]] <= cfg_wdata_in[nsr_pkg::LS_DIR_LO +: 4];
         link_net_reg[link_idx[2:0]] <= cfg_wdata_in[nsr_pkg::LS_NET_LO +: 2];
      end
   end

   // Shared halt: any enabled halted tile or the external pin
   always_comb begin
      shared_next = ext_debug_pin_in
                  | (halted_flag_in[0] & dbg_cfg_reg[0][nsr_pkg::DBG_DRIVE_BIT])
                  | (halted_flag_in[1] & dbg_cfg_reg[1][nsr_pkg::DBG_DRIVE_BIT]);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shared_prev_reg        <= 1'b0;
         shared_halt_signal_out <= 1'b0;
         core_debug_req_out     <= 2'b00;
      end else if (ce_in) begin
         shared_prev_reg        <= shared_next;
         shared_halt_signal_out <= shared_next;
         for (int t = 0; t < 2; t++) begin
            core_debug_req_out[t] <= shared_next & dbg_cfg_reg[t][nsr_pkg::DBG_REQ_BIT];
         end
      end
   end

   // Origin captured on each new event; a software write loses to a new event
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         origin_reg <= 5'h00;
      end else if (ce_in) begin
         if (shared_next && !shared_prev_reg) begin
            origin_reg <= '0;
            origin_reg[nsr_pkg::ORIG_PIN_BIT]  <= ext_debug_pin_in;
            origin_reg[nsr_pkg::ORIG_ONE_BIT]  <= halted_flag_in[1]
                                                & dbg_cfg_reg[1][nsr_pkg::DBG_DRIVE_BIT];
            origin_reg[nsr_pkg::ORIG_ZERO_BIT] <= halted_flag_in[0]
                                                & dbg_cfg_reg[0][nsr_pkg::DBG_DRIVE_BIT];
         end else if (cfg_wr_in && cfg_addr_in == nsr_pkg::REG_DBG_ORIGIN) begin
            origin_reg[nsr_pkg::ORIG_PIN_BIT]  <= cfg_wdata_in[nsr_pkg::ORIG_PIN_BIT];
            origin_reg[nsr_pkg::ORIG_ONE_BIT]  <= cfg_wdata_in[nsr_pkg::ORIG_ONE_BIT];
            origin_reg[nsr_pkg::ORIG_ZERO_BIT] <= cfg_wdata_in[nsr_pkg::ORIG_ZERO_BIT];
         end
      end
   end

   // Read mux
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (cfg_addr_in == nsr_pkg::REG_REF_DIV) begin
         rdata_next[15:0] = ref_div_reg;
      end else if (cfg_addr_in == nsr_pkg::REG_NODE_ID) begin
         rdata_next[15:0] = node_id_reg;
      end else if (cfg_addr_in == nsr_pkg::REG_SCAN_ID) begin
         rdata_next = nsr_pkg::SCAN_ID_VALUE;
      end else if (cfg_addr_in == nsr_pkg::REG_USER_CODE) begin
         rdata_next = nsr_pkg::USER_CODE_VAL;
      end else if (cfg_addr_in == nsr_pkg::REG_DIR_LOW) begin
         rdata_next = dir_low_reg;
      end else if (cfg_addr_in == nsr_pkg::REG_DIR_HIGH) begin
         rdata_next = dir_high_reg;
      end else if (cfg_addr_in == nsr_pkg::REG_DBG_TILE0) begin
         rdata_next[1:0] = dbg_cfg_reg[0];
      end else if (cfg_addr_in == nsr_pkg::REG_DBG_TILE1) begin
         rdata_next[1:0] = dbg_cfg_reg[1];
      end else if (cfg_addr_in == nsr_pkg::REG_DBG_ORIGIN) begin
         rdata_next[4:0] = origin_reg;
      end else if (link_hit) begin
         rdata_next[nsr_pkg::LS_KIND_LO +: 2] = link_kind_in[2*link_idx[2:0] +: 2];
         rdata_next[nsr_pkg::LS_DEST_LO +: 8] = link_dest_in[8*link_idx[2:0] +: 8];
         rdata_next[nsr_pkg::LS_DIR_LO +: 4]  = link_dir_reg[link_idx[2:0]];
         rdata_next[nsr_pkg::LS_NET_LO +: 2]  = link_net_reg[link_idx[2:0]];
         rdata_next[nsr_pkg::LS_JUNK_BIT]     = link_junk_in[link_idx[2:0]];
         rdata_next[nsr_pkg::LS_DST_USE_BIT]  = link_dst_use_in[link_idx[2:0]];
         rdata_next[nsr_pkg::LS_SRC_USE_BIT]  = link_src_use_in[link_idx[2:0]];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg_rdata_out  <= 32'h0000_0000;
         cfg_rvalid_out <= 1'b0;
      end else if (ce_in) begin
         cfg_rvalid_out <= cfg_rd_in;
         if (cfg_rd_in) begin
            cfg_rdata_out <= rdata_next;
         end
      end
   end

   // Registered copies of steering state
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_divider_out <= nsr_pkg::REF_DIV_RESET;
         link_dir_out    <= '0;
         link_net_out    <= '0;
      end else if (ce_in) begin
         ref_divider_out <= ref_div_reg;
         for (int i = 0; i < LINKS; i++) begin
            link_dir_out[4*i +: 4] <= link_dir_reg[i];
            link_net_out[2*i +: 2] <= link_net_reg[i];
         end
      end
   end

   assign route_valid_out = rt.valid;
   assign route_local_out = rt.local_hit;
   assign route_dir_out   = rt.direction;
endmodule

// [nsr_regs_checker.sv]
// Purpose: Port assertions for the node switch register bank
// Assumes: One clock, sync active-high reset
// Notes:   Link writes assumed on 0x20..0x27 only
`timescale 1ns/1ns
module nsr_regs_checker #(
   parameter int LINKS = 8
) (
   input wire logic               clk_in,
   input wire logic               rst_in,
   input wire logic               ce_in,
   input wire logic               cfg_wr_in,
   input wire logic               cfg_rd_in,
   input wire logic [7:0]         cfg_addr_in,
   input wire logic [31:0]        cfg_wdata_in,
   input wire logic [31:0]        cfg_rdata_out,
   input wire logic               cfg_rvalid_out,
   input wire logic               route_req_in,
   input wire logic               route_valid_out,
   input wire logic               route_local_out,
   input wire logic [3:0]         route_dir_out,
   input wire logic [15:0]        ref_divider_out,
   input wire logic               ext_debug_pin_in,
   input wire logic               shared_halt_signal_out,
   input wire logic [4*LINKS-1:0] link_dir_out,
   input wire logic [2*LINKS-1:0] link_net_out
);
   logic wr_div;
   logic wr_link;
   logic div_pend;
   logic link_pend;
   assign wr_div = ce_in && cfg_wr_in && cfg_addr_in == nsr_pkg::REG_REF_DIV;
   assign wr_link = ce_in && cfg_wr_in && cfg_addr_in[7:3] == 5'h04;
   // Output copies move one enabled edge after the register itself
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_pend  <= 1'b0;
         link_pend <= 1'b0;
      end else if (ce_in) begin
         div_pend  <= wr_div;
         link_pend <= wr_link;
      end
   end
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   AST_RV_SET: assert property (ce_in && cfg_rd_in |=> cfg_rvalid_out)
      else $error("read gave no valid");
   AST_RV_PULSE: assert property (ce_in && !cfg_rd_in |=> !cfg_rvalid_out)
      else $error("valid without read");
   // Reset edge guarded: old data may still sit there
   AST_RD_HOLD: assert property (!$past(rst_in) && !cfg_rvalid_out |-> $stable(cfg_rdata_out))
      else $error("read data moved without read");
   AST_DIV_WR: assert property (wr_div ##1 ce_in |=>
      ref_divider_out == $past(cfg_wdata_in[15:0], 2)) else $error("divider write lost");
   AST_DIV_ONLY: assert property (!$past(rst_in) && $changed(ref_divider_out) |->
      $past(div_pend && ce_in)) else $error("divider moved without write");
   AST_RST_VAL: assert property ($fell(rst_in) |->
      ref_divider_out == nsr_pkg::REF_DIV_RESET && link_dir_out == '0 && link_net_out == '0)
      else $error("bad reset values");
   AST_ROUTE: assert property (ce_in && route_req_in |=> route_valid_out)
      else $error("route answer missing");
   AST_LOCAL: assert property (route_valid_out && route_local_out |-> route_dir_out == 4'h0)
      else $error("local route with direction");
   AST_PIN: assert property (ce_in && ext_debug_pin_in |=> shared_halt_signal_out)
      else $error("pin did not raise halt");
   AST_LINK: assert property (!$past(rst_in) && $changed(link_dir_out) |->
      $past(link_pend && ce_in)) else $error("link direction moved");
endmodule
bind nsr_regs nsr_regs_checker #(.LINKS(LINKS)) nsr_regs_checker_i (
   .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .cfg_wr_in(cfg_wr_in),
   .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
   .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
   .route_req_in(route_req_in), .route_valid_out(route_valid_out),
   .route_local_out(route_local_out), .route_dir_out(route_dir_out),
   .ref_divider_out(ref_divider_out), .ext_debug_pin_in(ext_debug_pin_in),
   .shared_halt_signal_out(shared_halt_signal_out), .link_dir_out(link_dir_out),
   .link_net_out(link_net_out));

// [nsr_regs_test.sv]
// Purpose: Self-checking bench for the node switch register bank
// Assumes: Inputs change on the falling edge
// Notes:   Expected words built from the register map
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module nsr_regs_test;
   logic        clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, req = 0, pin = 0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [15:0] dest = 16'h0000;
   logic [1:0]  halt = 2'h0;
   logic [15:0] kind = 16'he4e4;
   logic [63:0] ldst = 64'ha7a6_a5a4_a3a2_a1a0;
   logic [7:0]  junk = 8'h5a, duse = 8'h33, suse = 8'h0f;
   logic [31:0] rdata, ldir;
   logic [15:0] div, lnet;
   logic [3:0]  rdir;
   logic [1:0]  creq;
   logic        rv, rvld, rloc, sh;
   int          fails = 0, check_count = 0;
   nsr_regs nsr_regs_i (.clk_in(clk), .rst_in(rst), .ce_in(ce), .cfg_wr_in(wr),
      .cfg_rd_in(rd), .cfg_addr_in(addr), .cfg_wdata_in(wd), .cfg_rdata_out(rdata),
      .cfg_rvalid_out(rv), .route_req_in(req), .route_dest_in(dest),
      .route_valid_out(rvld), .route_local_out(rloc), .route_dir_out(rdir),
      .ref_divider_out(div), .halted_flag_in(halt), .ext_debug_pin_in(pin),
      .shared_halt_signal_out(sh), .core_debug_req_out(creq), .link_kind_in(kind),
      .link_dest_in(ldst), .link_junk_in(junk), .link_dst_use_in(duse),
      .link_src_use_in(suse), .link_dir_out(ldir), .link_net_out(lnet));
   always #5 clk = ~clk;
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      wr = 1;
      addr = a;
      wd = d;
      @(negedge clk);
      wr = 0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(negedge clk);
      rd = 1;
      addr = a;
      @(negedge clk);
      rd = 0;
      `CHK("rvalid", 1'b1, rv)
      `CHK("rdata", e, rdata)
   endtask
   function automatic logic [31:0] lexp(int i, logic [3:0] d);
      return {6'h0, kind[2*i+:2], ldst[8*i+:8], 4'h0, d, 2'h0, d[1:0], 1'b0,
         junk[i], duse[i], suse[i]};
   endfunction
   task automatic t_regs;
      rchk(nsr_pkg::REG_REF_DIV, 32'h0000_0003);
      rchk(nsr_pkg::REG_SCAN_ID, nsr_pkg::SCAN_ID_VALUE);
      rchk(nsr_pkg::REG_USER_CODE, nsr_pkg::USER_CODE_VAL);
      rchk(nsr_pkg::REG_DIR_LOW, 32'h0000_0000);
      rchk(nsr_pkg::REG_DIR_HIGH, 32'h0000_0000);
      rchk(nsr_pkg::REG_NODE_ID, 32'h0000_0000);
      rchk(nsr_pkg::REG_DBG_TILE1, 32'h0000_0000);
      wreg(nsr_pkg::REG_REF_DIV, 32'hffff_ffff);
      rchk(nsr_pkg::REG_REF_DIV, 32'h0000_ffff);
      `CHK("divider", 16'hffff, div)
      wreg(nsr_pkg::REG_SCAN_ID, 32'h0000_0000);
      rchk(nsr_pkg::REG_SCAN_ID, nsr_pkg::SCAN_ID_VALUE);
      wreg(nsr_pkg::REG_USER_CODE, 32'hffff_ffff);
      rchk(nsr_pkg::REG_USER_CODE, nsr_pkg::USER_CODE_VAL);
      wreg(8'h30, 32'hffff_ffff);
      rchk(8'h30, 32'h0000_0000);
      // Clock enable low must swallow the write
      ce = 0;
      wreg(nsr_pkg::REG_REF_DIV, 32'h0000_0005);
      ce = 1;
      rchk(nsr_pkg::REG_REF_DIV, 32'h0000_ffff);
      $display("done regs");
   endtask
   task automatic t_route;
      wreg(nsr_pkg::REG_NODE_ID, 32'hffff_a5c3);
      rchk(nsr_pkg::REG_NODE_ID, 32'h0000_a5c3);
      // Dimension k holds k+1 (dimension 15 wraps to 0), so a local hit can not pass as dimension 0
      wreg(nsr_pkg::REG_DIR_LOW, 32'h8765_4321);
      wreg(nsr_pkg::REG_DIR_HIGH, 32'h0fed_cba9);
      rchk(nsr_pkg::REG_DIR_LOW, 32'h8765_4321);
      rchk(nsr_pkg::REG_DIR_HIGH, 32'h0fed_cba9);
      // Flip bit k and all below: top mismatch is k
      for (int k = -1; k < 16; k++) begin
         @(negedge clk);
         req = 1;
         dest = (k < 0) ? 16'ha5c3 : 16'ha5c3 ^ 16'((32'h2 << k) - 1);
         @(negedge clk);
         req = 0;
         `CHK("route_valid", 1'b1, rvld)
         `CHK("route_local", k < 0, rloc)
         `CHK("route_dir", (k < 0) ? 4'h0 : 4'(k + 1), rdir)
      end
      $display("done route");
   endtask
   task automatic t_debug;
      wreg(nsr_pkg::REG_DBG_TILE0, 32'hffff_fffd);
      rchk(nsr_pkg::REG_DBG_TILE0, 32'h0000_0001);
      wreg(nsr_pkg::REG_DBG_TILE1, 32'h0000_0002);
      rchk(nsr_pkg::REG_DBG_TILE1, 32'h0000_0002);
      wreg(nsr_pkg::REG_DBG_ORIGIN, 32'h0000_0000);
      halt = 2'b10;
      repeat (3) @(negedge clk);
      `CHK("halt_off", 1'b0, sh)
      halt = 2'b01;
      repeat (3) @(negedge clk);
      `CHK("halt_on", 1'b1, sh)
      `CHK("core_req", 2'b10, creq)
      rchk(nsr_pkg::REG_DBG_ORIGIN, 32'h0000_0001);
      halt = 2'b00;
      wreg(nsr_pkg::REG_DBG_ORIGIN, 32'h0000_0000);
      pin = 1;
      repeat (3) @(negedge clk);
      `CHK("halt_pin", 1'b1, sh)
      rchk(nsr_pkg::REG_DBG_ORIGIN, 32'h0000_0010);
      pin = 0;
      wreg(nsr_pkg::REG_DBG_TILE1, 32'h0000_0003);
      halt = 2'b10;
      repeat (3) @(negedge clk);
      rchk(nsr_pkg::REG_DBG_ORIGIN, 32'h0000_0002);
      halt = 2'b00;
      $display("done debug");
   endtask
   task automatic t_links;
      for (int i = 0; i < 8; i++) begin
         rchk(nsr_pkg::REG_LINK_BASE + 8'(i), lexp(i, 4'h0));
         wreg(nsr_pkg::REG_LINK_BASE + 8'(i), {20'hf_ffff, 4'(i), 2'b11, 2'(i), 4'hf});
         rchk(nsr_pkg::REG_LINK_BASE + 8'(i), lexp(i, 4'(i)));
         `CHK("link_dir", 4'(i), ldir[4*i+:4])
         `CHK("link_net", 2'(i), lnet[2*i+:2])
      end
      $display("done links");
   endtask
   task automatic results;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 0;
      t_regs;
      t_route;
      t_debug;
      t_links;
      results;
   end
   // Whole run is well under a thousand cycles
   initial begin
      #100000;
      fails++;
      results;
   end
endmodule
